// [design/olc_otp_consts.svh]
// Constants for the OTP program controller
`ifndef OLC_OTP_CONSTS_SVH
`define OLC_OTP_CONSTS_SVH
// ****************************************
// Control register fields
// ****************************************
`define OLC_START_BIT 7
`define OLC_CMD_HI 6
`define OLC_CMD_LO 5
`define OLC_ADDR_HI 3
`define OLC_ADDR_LO 0
// ****************************************
// Array geometry and special bytes
// ****************************************
`define OLC_BYTES 14
`define OLC_LAST_ADDR 4'hd
`define OLC_FLOCK_ADDR 4'h2
`define OLC_ULOCK_ADDR 4'h3
`define OLC_LOCK_BIT 7
`define OLC_FIXED_ADDR 4'ha
// Factory trimming bits per byte, lock bit of byte 2 included
`define OLC_TRIM_MASK 112'h0000_80_00_00_00_00_1f_ff_ff_0f_f0_ff_00
// Bits that do not exist in the array
`define OLC_VOID_MASK 112'h0000_00_00_00_00_00_00_00_00_00_00_00_e0
// Serial-rewritable user bits of the fixed byte
`define OLC_FIXED_WMASK 8'h00
// ****************************************
// Reset values
// ****************************************
`define OLC_CTRL_RST 8'h00
`define OLC_DATA_RST 8'h00
`endif

// [design/olc_otp_pkg.sv]
// Types shared by the OTP program controller
package olc_otp_pkg;
	// Command codes in the control register
	typedef enum logic [1:0] {
		OLC_CMD_POINT = 2'h0,
		OLC_CMD_READ = 2'h1,
		OLC_CMD_LOAD = 2'h2,
		OLC_CMD_ZAP = 2'h3
	} olc_cmd_type;
	// One-hot controller states
	typedef enum logic [5:0] {
		OLC_ST_BOOT = 6'h01,
		OLC_ST_IDLE = 6'h02,
		OLC_ST_READ = 6'h04,
		OLC_ST_LOAD = 6'h08,
		OLC_ST_ZAP = 6'h10,
		OLC_ST_REFRESH = 6'h20
	} olc_state_type;
	// Configuration fields driven to the ballast logic
	typedef struct packed {
		logic [7:0] dim_duty_1;
		logic [7:0] dim_duty_2;
		logic [6:0] current_1;
		logic [6:0] current_2;
		logic [7:0] short_thr_1;
		logic [7:0] short_thr_2;
		logic diag_mode;
		logic [2:0] boost_rate;
		logic boost_disable_bit;
		logic derating_disable_bit;
		logic [2:0] dim_freq;
	} olc_cfg_type;
	// Serial register write strobe with its data
	typedef struct packed {
		logic wr;
		logic [7:0] wdata;
	} olc_wr_type;
	// Serial configuration write
	typedef struct packed {
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} olc_cfg_wr_type;
endpackage

// [design/olc_otp_ctrl.sv]
// OTP program controller: fuse array, command engine and configuration shadow
//
// Overview of operation
// R1: Array holds 109 bits: 38 trim, 71 user.
// R2: Startup copies array into configuration registers.
// R3: Commands only in test mode, lock-restricted.
// R4: Host keeps test pin high during operations.
// R5: Setting start bit launches selected command.
// R6: Command in bits 6:5, address 3:0.
// R7: Point copies byte to data, no start.
// R8: Read copies byte then refreshes configuration.
// R9: Load shifts data into chain, refreshes.
// R10: Zap burns bitwise, refreshes; ones stay.
// R11: Data write stores byte for load.
// R12: Data read returns stored array byte.
// R13: Address latched at start until done.
// R14: Start bit self-clears when command completes.
// R15: Host zaps only with LEDs off.
// R16: Lock bits once set stay set.
// R17: Factory lock blocks trimming bit programming.
// R18: User lock blocks user parameter programming.
// R19: Serial rewrites allowed except rate, diag mode.
// R20: Bytes 0-3: duty factors and currents.
// R21: Bytes 4-5: individual short thresholds.
// R22: Byte A: diag mode, boost rate, trim.
// R23: Byte D: boost, derating disable, dim freq.
// R24: Control writes ignored while command runs.
`timescale 1ns/1ps
`include "olc_otp_consts.svh"
module olc_otp_ctrl #(
	parameter int BYTES = `OLC_BYTES,
	parameter logic [111:0] FUSE_INIT = 112'h0
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic test_enable_pin, // Level, high enables OTP access
	input wire olc_otp_pkg::olc_wr_type ctrl_wr, // control_reg_nine write
	input wire olc_otp_pkg::olc_wr_type data_wr, // control_reg_ten write
	input wire olc_otp_pkg::olc_cfg_wr_type cfg_wr, // Config rewrite
	output logic [7:0] ctrl_rdata, // control_reg_nine read value
	output logic [7:0] data_rdata, // control_reg_ten read value
	output olc_otp_pkg::olc_cfg_type cfg, // Configuration to ballast
	output logic factory_trim_lock, // Level
	output logic user_param_lock // Level
);
	import olc_otp_pkg::*;

	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] fuse [0:BYTES-1]; // Nonvolatile cells
	logic [7:0] shadow [0:BYTES-1]; // Configuration registers
	logic [7:0] load_byte; // Byte for the next load
	logic [7:0] chain; // Programming chain at latched address
	logic start; // Start flag, self-clearing
	olc_cmd_type cmd; // Command field
	logic [3:0] addr; // Address field, latched
	olc_state_type state; // Controller state
	logic [2:0] bit_cnt; // Bit position for load and zap
	logic [7:0] sel_byte; // Array byte at address field
	logic [7:0] burn_mask; // Bits that may be burned now
	logic [111:0] trim_mask; // Factory bits, flattened
	logic [111:0] void_mask; // Absent bits, flattened
	logic launch; // Accepted start

	assign trim_mask = `OLC_TRIM_MASK;
	assign void_mask = `OLC_VOID_MASK;

	// Out-of-range addresses read as zero
	always_comb begin
		sel_byte = 8'h00;
		if (addr <= `OLC_LAST_ADDR) begin
			sel_byte = fuse[addr];
		end
	end

	// R3 lock-aware burn mask for latched byte
	always_comb begin
		burn_mask = 8'h00;
		if (addr <= `OLC_LAST_ADDR) begin
			// R17 factory lock gates trim bits
			// R18 user lock gates user bits
			burn_mask = ~void_mask[111 - 8*addr -: 8] &
				(factory_trim_lock ? ~trim_mask[111 - 8*addr -: 8] : 8'hff) &
				(user_param_lock ? trim_mask[111 - 8*addr -: 8] : 8'hff);
		end
	end

	// R5 start accepted only when idle in test mode
	assign launch = ctrl_wr.wr && ctrl_wr.wdata[`OLC_START_BIT] &&
		test_enable_pin && (state == OLC_ST_IDLE);

	// ****************************************
	// Control register
	// ****************************************
	// Fields update on writes while idle; busy writes are dropped
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			start <= 1'b0;
			cmd <= OLC_CMD_POINT;
			addr <= 4'h0;
		end else if (state == OLC_ST_REFRESH ||
			(state == OLC_ST_READ && cmd == OLC_CMD_POINT)) begin
			// R14 start self-clears at completion
			start <= 1'b0;
		end else if (ctrl_wr.wr && state == OLC_ST_IDLE) begin
			// R6 command and address fields
			// R13 address taken with the start bit
			cmd <= olc_cmd_type'(ctrl_wr.wdata[`OLC_CMD_HI:`OLC_CMD_LO]);
			addr <= ctrl_wr.wdata[`OLC_ADDR_HI:`OLC_ADDR_LO];
			start <= launch;
		end
		// R24 writes while busy fall through here
	end

	// ****************************************
	// Command engine
	// ****************************************
	// Startup refresh, then commands one at a time
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= OLC_ST_BOOT;
			bit_cnt <= 3'h0;
		end else begin
			unique case (state)
				OLC_ST_BOOT: begin
					// R2 startup load
					state <= OLC_ST_REFRESH;
				end
				OLC_ST_IDLE: begin
					bit_cnt <= 3'h0;
					if (launch) begin
						unique case (olc_cmd_type'(ctrl_wr.wdata[`OLC_CMD_HI:`OLC_CMD_LO]))
							OLC_CMD_POINT, OLC_CMD_READ: state <= OLC_ST_READ;
							OLC_CMD_LOAD: state <= OLC_ST_LOAD;
							OLC_CMD_ZAP: state <= OLC_ST_ZAP;
						endcase
					end
				end
				OLC_ST_READ: begin
					// R8 read goes on to refresh, point does not
					state <= (cmd == OLC_CMD_READ) ? OLC_ST_REFRESH : OLC_ST_IDLE;
				end
				OLC_ST_LOAD, OLC_ST_ZAP: begin
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7) begin
						state <= OLC_ST_REFRESH;
					end
				end
				OLC_ST_REFRESH: begin
					state <= OLC_ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Data register and chain
	// ****************************************
	// R11 serial write keeps byte for load
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			load_byte <= `OLC_DATA_RST;
		end else if (data_wr.wr) begin
			load_byte <= data_wr.wdata;
		end
	end

	// R9 chain takes the data byte one bit per cycle, LSB first
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			chain <= 8'h00;
		end else if (state == OLC_ST_LOAD) begin
			chain <= {load_byte[bit_cnt], chain[7:1]};
		end
	end

	// R12 read value comes from the array, not the write
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			data_rdata <= `OLC_DATA_RST;
		end else if (state == OLC_ST_READ) begin
			// R8 copy on read command
			data_rdata <= sel_byte;
		end else if (state == OLC_ST_IDLE && cmd == OLC_CMD_POINT && test_enable_pin) begin
			// R7 point tracks the cell without start
			data_rdata <= sel_byte;
		end
	end

	// Read view of the control register
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ctrl_rdata <= `OLC_CTRL_RST;
		end else begin
			ctrl_rdata <= {next_start_view(), cmd, 1'b0, addr};
		end
	end

	// Keeps the start view aligned with the cleared flag
	function automatic logic next_start_view();
		next_start_view = start && !(state == OLC_ST_REFRESH ||
			(state == OLC_ST_READ && cmd == OLC_CMD_POINT));
	endfunction

	// ****************************************
	// Fuse array and configuration shadow
	// ****************************************
	// R1 fourteen bytes, 109 real bits
	// Cells re-sense FUSE_INIT at reset, standing in for the macro; byte 0 sits in the top bits
	for (genvar b = 0; b < BYTES; b++) begin : g_byte
		always_ff @(posedge sys_clk) begin
			if (!reset_n) begin
				fuse[b] <= FUSE_INIT[111 - 8*b -: 8] & ~void_mask[111 - 8*b -: 8];
			end else if (state == OLC_ST_ZAP && addr == 4'(b) &&
				chain[bit_cnt] && burn_mask[bit_cnt]) begin
				// R10 one bit per cycle; burning only sets
				// R16 locks can only be set
				fuse[b][bit_cnt] <= 1'b1;
			end
		end

		always_ff @(posedge sys_clk) begin
			if (!reset_n) begin
				shadow[b] <= 8'h00;
			end else if (state == OLC_ST_REFRESH) begin
				// R2 full reload from the array
				shadow[b] <= fuse[b];
			end else if (cfg_wr.wr && cfg_wr.addr == 4'(b)) begin
				// R19 rate and diag mode stay from the array
				if (4'(b) == `OLC_FIXED_ADDR) begin
					shadow[b] <= (cfg_wr.wdata & `OLC_FIXED_WMASK) |
						(shadow[b] & ~`OLC_FIXED_WMASK);
				end else begin
					shadow[b] <= (cfg_wr.wdata & ~trim_mask[111 - 8*b -: 8]) |
						(shadow[b] & trim_mask[111 - 8*b -: 8]);
				end
			end
		end
	end

	// R20 R21 R22 R23 field placement
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cfg <= '0;
		end else begin
			cfg.dim_duty_1 <= shadow[0];
			cfg.dim_duty_2 <= shadow[1];
			cfg.current_1 <= shadow[2][6:0];
			cfg.current_2 <= shadow[3][6:0];
			cfg.short_thr_1 <= shadow[4];
			cfg.short_thr_2 <= shadow[5];
			cfg.diag_mode <= shadow[10][7];
			cfg.boost_rate <= shadow[10][6:4];
			cfg.boost_disable_bit <= shadow[13][4];
			cfg.derating_disable_bit <= shadow[13][3];
			cfg.dim_freq <= shadow[13][2:0];
		end
	end

	// R17 R18 lock bits follow their cells
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			factory_trim_lock <= 1'b0;
			user_param_lock <= 1'b0;
		end else begin
			factory_trim_lock <= fuse[`OLC_FLOCK_ADDR][`OLC_LOCK_BIT];
			user_param_lock <= fuse[`OLC_ULOCK_ADDR][`OLC_LOCK_BIT];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_run8(olc_state_type st);
		(state == st)[*8];
	endsequence
	sequence s_finish;
		state == OLC_ST_REFRESH ##1 state == OLC_ST_IDLE && !start;
	endsequence
	property p_boot;
		state == OLC_ST_BOOT && reset_n |=> s_finish;
	endproperty
	a_boot: assert property (p_boot) else $error("startup refresh missing"); // R2
	property p_load_seq;
		$rose(state == OLC_ST_LOAD) |-> s_run8(OLC_ST_LOAD) ##1 s_finish;
	endproperty
	a_load_seq: assert property (p_load_seq) else $error("load sequence wrong"); // R9
	property p_zap_seq;
		$rose(state == OLC_ST_ZAP) |-> s_run8(OLC_ST_ZAP) ##1 s_finish;
	endproperty
	a_zap_seq: assert property (p_zap_seq) else $error("zap sequence wrong"); // R10
	property p_addr_hold;
		start && $past(start) |-> $stable(addr) && $stable(cmd);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved while busy"); // R13
	property p_launch;
		launch |=> start && state != OLC_ST_IDLE;
	endproperty
	a_launch: assert property (p_launch) else $error("start not taken"); // R5
	property p_no_test;
		!test_enable_pin && state == OLC_ST_IDLE |=> state == OLC_ST_IDLE;
	endproperty
	a_no_test: assert property (p_no_test) else $error("command outside test mode"); // R3
	property p_fuse_mono;
		sel_byte == ($past(sel_byte) | sel_byte) || $changed(addr);
	endproperty
	a_fuse_mono: assert property (p_fuse_mono) else $error("fuse bit cleared"); // R10
	property p_flock;
		factory_trim_lock |=> factory_trim_lock;
	endproperty
	a_flock: assert property (p_flock) else $error("factory lock released"); // R16
	property p_ulock;
		user_param_lock |=> user_param_lock;
	endproperty
	a_ulock: assert property (p_ulock) else $error("user lock released"); // R16
	property p_trim_locked;
		factory_trim_lock && state == OLC_ST_ZAP && addr <= `OLC_LAST_ADDR |=>
			((sel_byte ^ $past(sel_byte)) & trim_mask[111 - 8*addr -: 8]) == 8'h00;
	endproperty
	a_trim_locked: assert property (p_trim_locked) else $error("trim burned under lock"); // R17
	property p_user_locked;
		user_param_lock && state == OLC_ST_ZAP && addr <= `OLC_LAST_ADDR |=>
			((sel_byte ^ $past(sel_byte)) & ~trim_mask[111 - 8*addr -: 8]) == 8'h00;
	endproperty
	a_user_locked: assert property (p_user_locked) else $error("user bit burned under lock"); // R18
	property p_refresh_cfg;
		state == OLC_ST_REFRESH |=> ##1 cfg.dim_duty_1 == fuse[0] && cfg.short_thr_2 == fuse[5];
	endproperty
	a_refresh_cfg: assert property (p_refresh_cfg) else $error("refresh did not reload"); // R8
	property p_read_data;
		state == OLC_ST_READ |=> data_rdata == $past(sel_byte);
	endproperty
	a_read_data: assert property (p_read_data) else $error("data read not from array"); // R12
endmodule

// [test/olc_host_model.sv]
// Host model: serial master that writes the OTP registers and drives the test pin
`timescale 1ns/1ps
module olc_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] ctrl_rdata,
	output logic test_enable_pin,
	output olc_otp_pkg::olc_wr_type ctrl_wr,
	output olc_otp_pkg::olc_wr_type data_wr,
	output olc_otp_pkg::olc_cfg_wr_type cfg_wr
);
	import olc_otp_pkg::*;
	// Idle cycles before data and config writes, so the host can be slow
	int gap = 0;
	// Polls that ran out before the start bit cleared
	int poll_miss = 0;
	// ****************************************
	// Idle levels
	// ****************************************
	// pin high default
	initial begin
		test_enable_pin = 1'b1;
		ctrl_wr = '{1'b0, 8'h00};
		data_wr = '{1'b0, 8'h00};
		cfg_wr = '{1'b0, 4'h0, 8'h00};
	end
	task automatic set_test(input logic lvl);
		@(posedge sys_clk);
		test_enable_pin <= lvl;
	endtask
	task automatic ctrl(input logic [7:0] v);
		@(posedge sys_clk);
		ctrl_wr <= '{1'b1, v};
		@(posedge sys_clk);
		// Released data is scrambled so a stale byte cannot be reused
		ctrl_wr <= '{1'b0, ~v};
	endtask
	task automatic data(input logic [7:0] v);
		repeat (gap) @(posedge sys_clk);
		@(posedge sys_clk);
		data_wr <= '{1'b1, v};
		@(posedge sys_clk);
		data_wr <= '{1'b0, ~v};
	endtask
	// Configuration rewrite of one byte
	task automatic cfg(input logic [3:0] a, input logic [7:0] v);
		repeat (gap) @(posedge sys_clk);
		@(posedge sys_clk);
		cfg_wr <= '{1'b1, a, v};
		@(posedge sys_clk);
		cfg_wr <= '{1'b0, ~a, ~v};
	endtask
	task automatic poll();
		int n;
		n = 0;
		repeat (2) @(posedge sys_clk);
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (ctrl_rdata[7] !== 1'b0 && n < 40);
		// A start bit that never clears is a hang, counted against the run
		if (ctrl_rdata[7] !== 1'b0) begin
			poll_miss++;
		end
	endtask
endmodule

// [test/tb_top.sv]
// Self-checking testbench of the OTP program controller
`timescale 1ns/1ps
`include "olc_otp_consts.svh"
`define TB_CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end
module tb_top;
	import olc_otp_pkg::*;
	// Array content after reset, byte 0 in the top bits
	localparam logic [111:0] FUSE = 112'h5a33_0011_4000_0000_0000_b000_0015;
	localparam logic [111:0] TRIM = `OLC_TRIM_MASK;
	localparam logic [111:0] VOID = `OLC_VOID_MASK;
	typedef struct {string name; int sel; logic [63:0] exp;} olc_note_type;
	logic sys_clk = 1'b0;
	logic reset_n;
	logic test_enable_pin;
	olc_wr_type ctrl_wr, data_wr;
	olc_cfg_wr_type cfg_wr;
	logic [7:0] ctrl_rdata, data_rdata;
	olc_cfg_type cfg;
	logic factory_trim_lock, user_param_lock;
	logic [7:0] mem [0:13]; // Expected array
	logic [7:0] shadow [0:13]; // Expected configuration bytes
	olc_note_type notes[$];
	event look;
	int failures = 0;
	int check_count = 0;
	int seed = 54;
	logic [7:0] rnd;
	olc_otp_ctrl #(.BYTES(`OLC_BYTES), .FUSE_INIT(FUSE)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
		.test_enable_pin(test_enable_pin), .ctrl_wr(ctrl_wr), .data_wr(data_wr), .cfg_wr(cfg_wr),
		.ctrl_rdata(ctrl_rdata), .data_rdata(data_rdata), .cfg(cfg),
		.factory_trim_lock(factory_trim_lock), .user_param_lock(user_param_lock));
	olc_host_model host_u (.sys_clk(sys_clk), .ctrl_rdata(ctrl_rdata), .test_enable_pin(test_enable_pin),
		.ctrl_wr(ctrl_wr), .data_wr(data_wr), .cfg_wr(cfg_wr));
	// 40 MHz clock
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	// ****************************************
	// Scoreboard
	// ****************************************
	task automatic note(input string nm, input int sel, input logic [63:0] e);
		notes.push_back('{nm, sel, e});
		-> look;
	endtask
	// Oldest note is compared with the output that it names
	always @(look) begin
		olc_note_type n;
		logic [63:0] got;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.sel)
				0: got = {56'h0, ctrl_rdata};
				1: got = {56'h0, data_rdata};
				2: got = 64'(cfg);
				default: got = {62'h0, factory_trim_lock, user_param_lock};
			endcase
			`TB_CHK(n.name, n.exp, got)
		end
	end
	task automatic test_done();
		failures += host_u.poll_miss;
		if (failures == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#75000;
		failures++;
		test_done();
	end
	// ****************************************
	// Reference model
	// ****************************************
	function automatic olc_cfg_type cfg_of();
		olc_cfg_type c;
		c = '{shadow[0], shadow[1], shadow[2][6:0], shadow[3][6:0], shadow[4], shadow[5], shadow[10][7],
			shadow[10][6:4], shadow[13][4], shadow[13][3], shadow[13][2:0]};
		return c;
	endfunction
	// Bits only go to one, and only where no lock guards them
	function automatic logic [7:0] burn(input int a, input logic [7:0] d);
		logic [7:0] t;
		t = TRIM[111 - 8 * a -: 8];
		return mem[a] | (d & ~VOID[111 - 8 * a -: 8] & ~(t & {8{mem[2][7]}}) & ~(~t & {8{mem[3][7]}}));
	endfunction
	task automatic point(input logic [3:0] a);
		host_u.ctrl({4'h0, a});
		repeat (3) @(posedge sys_clk);
		#1;
		note("point data", 1, {56'h0, (a < 14) ? mem[a] : 8'h00});
	endtask
	// Load then zap, with a control write dropped while busy
	task automatic zap(input logic [3:0] a, input logic [7:0] d);
		host_u.gap = $unsigned($random(seed)) % 4;
		host_u.data(d);
		host_u.ctrl({4'hc, a});
		host_u.poll();
		note("load ctrl", 0, {56'h0, 4'h4, a});
		host_u.ctrl({4'he, a});
		host_u.ctrl(8'ha5);
		@(posedge sys_clk);
		#1;
		note("busy ctrl", 0, {56'h0, 4'he, a});
		host_u.poll();
		mem[a] = burn(a, d);
		shadow = mem;
		@(posedge sys_clk);
		#1;
		note("zap ctrl", 0, {56'h0, 4'h6, a});
		note("zap cfg", 2, 64'(cfg_of()));
		note("locks", 3, {62'h0, mem[2][7], mem[3][7]});
		point(a);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset_n = 1'b0;
		for (int i = 0; i < 14; i++) begin
			mem[i] = FUSE[111 - 8 * i -: 8];
		end
		shadow = mem;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		note("reset ctrl", 0, 64'h0);
		note("boot cfg", 2, 64'(cfg_of()));
		note("boot locks", 3, 64'h0);
		for (int a = 0; a < 16; a++) begin
			point(4'(a));
		end
		// Serial rewrites; trim bits and the fixed byte hold
		for (int a = 0; a < 14; a++) begin
			rnd = 8'($random(seed));
			host_u.cfg(4'(a), rnd);
			if (a != 10) begin
				shadow[a] = (shadow[a] & TRIM[111 - 8 * a -: 8]) | (rnd & ~TRIM[111 - 8 * a -: 8]);
			end
		end
		repeat (3) @(posedge sys_clk);
		#1;
		note("rewritten cfg", 2, 64'(cfg_of()));
		host_u.ctrl(8'ha5);
		host_u.poll();
		shadow = mem;
		@(posedge sys_clk);
		#1;
		note("read ctrl", 0, 64'h25);
		note("read data", 1, {56'h0, mem[5]});
		note("read cfg", 2, 64'(cfg_of()));
		// Start refused while the test pin is low
		host_u.cfg(4'h0, 8'hc3);
		shadow[0] = 8'hc3;
		host_u.set_test(1'b0);
		host_u.ctrl(8'ha1);
		repeat (12) @(posedge sys_clk);
		#1;
		note("no start", 0, 64'h21);
		note("kept cfg", 2, 64'(cfg_of()));
		host_u.set_test(1'b1);
		rnd = 8'($random(seed));
		zap(4'h4, rnd);
		zap(4'h4, 8'h00);
		zap(4'h3, 8'h80);
		zap(4'h1, 8'hff);
		zap(4'h2, 8'h80);
		zap(4'h7, 8'hff);
		zap(4'h8, 8'hff);
		#1;
		test_done();
	end
endmodule
